// [hw/serial_if_params.svh]
`ifndef SERIAL_IF_PARAMS_SVH
`define SERIAL_IF_PARAMS_SVH
// register indices, byte address is four times the index
`define PIN_FUNCTION_SELECT_IDX 6'h0B
`define MODULE_CLOCK_GATE_IDX   6'h0E
`define SERIAL_MODE_ONE_IDX     6'h24
`define SERIAL_MODE_TWO_IDX     6'h25
`define SHIFT_DATA_LOW_IDX      6'h26
`define SHIFT_DATA_HIGH_IDX     6'h27
// registers of our own
`define START_COMMAND_IDX       6'h30
`define STATUS_IDX              6'h31
// field positions
`define CONT_CLOCK_SELECT_BIT   3
`define PIN_DATA_OUT_BIT        2
`define PIN_CLOCK_BIT           1
`define IDLE_LEVEL_BIT          1
`define PULLUP_ENABLE_BIT       2
`define MODE_EXT_CLOCK_CODE     3'h7
`define GATE_SERIAL_BIT         0
// reset values
`define SERIAL_MODE_ONE_RST     4'h0
`define PIN_FUNCTION_RST        4'h0
`define GATE_RST                4'h0
// timing
`define BITS_PER_TRANSFER       4'h8
`define MODE_SETTLE_CYCLES      2'h2
`endif

// [hw/serial_if_pkg.sv]
package serial_if_pkg;
  typedef enum logic [1:0] {
    ST_START_WAIT,
    ST_CLOCK_WAIT,
    ST_TRANSFER,
    ST_CONT_CLOCK
  } serial_state_type;
endpackage : serial_if_pkg

// [hw/clocked_serial_interface.sv]
`timescale 1ns/1ps
`include "serial_if_params.svh"
module clocked_serial_interface
  import serial_if_pkg::*;
(
  input  wire logic        core_clk,          // system clock, 10 MHz
  input  wire logic        rst,               // synchronous reset, high
  input  wire logic [7:0]  avs_address,       // word address
  input  wire logic        avs_read,          // read strobe
  input  wire logic        avs_write,         // write strobe
  input  wire logic [31:0] avs_writedata,     // write data
  input  wire logic [3:0]  avs_byteenable,    // byte enables
  output logic      [31:0] avs_readdata,      // read data
  output logic             avs_waitrequest,   // stall
  input  wire logic        sclkIn,            // serial clock pin level
  output logic             sclkOut,           // serial clock drive value
  output logic             sclkOe,            // serial clock drive enable
  input  wire logic        serialIn,          // serial data in pin
  output logic             serialOut,         // serial data out
  output logic             serialOutOe,       // serial data out enable
  output logic             pullupEn,          // pull-up pmos on
  output logic             serialIrqFlag      // irq flag level
);

  // register state
  serial_state_type state_ff, nxt_state;
  logic [3:0] serial_mode_one_ff, nxt_serial_mode_one;
  logic [3:0] pending_mode_ff, nxt_pending_mode;
  logic [1:0] settle_ff, nxt_settle;
  logic [3:0] pin_function_select_ff, nxt_pin_function_select;
  logic [3:0] module_clock_gate_ff, nxt_module_clock_gate;
  logic       idle_level_ff, nxt_idle_level;
  logic       pullup_ff, nxt_pullup;
  logic [7:0] shift_ff, nxt_shift;
  logic [3:0] bit_counter_ff, nxt_bit_counter;
  logic       serial_irq_flag_ff, nxt_serial_irq_flag;
  logic       out_ff, nxt_out;
  logic       sclk_drv_ff, nxt_sclk_drv;
  logic [1:0] pre_cnt_ff, nxt_pre_cnt;
  logic       first_low_ff, nxt_first_low;
  logic       ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [2:0] sclk_sync_ff;
  logic       sclk_level_ff, nxt_sclk_level;
  logic [2:0] sin_sync_ff;
  logic       sclk_oe_ff, nxt_sclk_oe;

  logic       extClock;
  logic       clkFall;
  logic       req;
  logic       wrMode1;
  logic       wrStart;
  logic       gated;
  logic       idleState;

  // external clock when mode one bits 2:0 hold the external clock code 7
  assign extClock  = (serial_mode_one_ff[2:0] == `MODE_EXT_CLOCK_CODE);
  assign gated     = module_clock_gate_ff[`GATE_SERIAL_BIT];
  assign req       = (avs_read | avs_write) & ~ack_ff;
  assign wrMode1   = avs_write & ~ack_ff & avs_byteenable[0]
                     & (avs_address[5:0] == `SERIAL_MODE_ONE_IDX);
  assign wrStart   = avs_write & ~ack_ff & avs_byteenable[0]
                     & (avs_address[5:0] == `START_COMMAND_IDX);
  assign idleState = (state_ff == ST_START_WAIT) | (state_ff == ST_CLOCK_WAIT);
  assign nxt_sclk_level = (sclk_sync_ff[1] == sclk_sync_ff[2]) ? sclk_sync_ff[2]
                                                              : sclk_level_ff;
  // drive enable registered from the mode that takes effect next
  assign nxt_sclk_oe = (nxt_serial_mode_one[2:0] != `MODE_EXT_CLOCK_CODE);

  // pin synchronisers, clock pin change accepted once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclk_sync_ff  <= 3'h7;
      sin_sync_ff   <= 3'h0;
      sclk_level_ff <= 1'b1;
    end else begin
      sclk_sync_ff  <= {sclk_sync_ff[1:0], sclkIn};
      sin_sync_ff   <= {sin_sync_ff[1:0], serialIn};
      sclk_level_ff <= nxt_sclk_level;
    end
  end

  // serial clock edges seen by the engine, from the selected source
  logic clkPrev_ff;
  logic clkNow;
  assign clkNow  = extClock ? nxt_sclk_level : nxt_sclk_drv;
  assign clkFall = clkPrev_ff & ~clkNow & ~gated;
  logic clkRiseEv;
  assign clkRiseEv = ~clkPrev_ff & clkNow & ~gated;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      clkPrev_ff <= 1'b1;
    end else begin
      clkPrev_ff <= clkNow;
    end
  end

  // engine next state
  always_comb begin
    nxt_state           = state_ff;
    nxt_bit_counter     = bit_counter_ff;
    nxt_serial_irq_flag = serial_irq_flag_ff;
    nxt_shift           = shift_ff;
    nxt_out             = out_ff;
    nxt_first_low       = first_low_ff;
    nxt_idle_level      = idle_level_ff;
    nxt_pullup          = pullup_ff;
    if (avs_write & ~ack_ff & avs_byteenable[0]) begin
      if ((avs_address[5:0] == `SERIAL_MODE_TWO_IDX) && (state_ff != ST_TRANSFER)) begin
        nxt_idle_level = avs_writedata[`IDLE_LEVEL_BIT];
        nxt_pullup     = avs_writedata[`PULLUP_ENABLE_BIT];
        // idle level drives output at once in start-wait or clock-wait
        if (idleState) begin
          nxt_out = avs_writedata[`IDLE_LEVEL_BIT];
        end
      end
      // software side writes shift halves in any state, transfers included
      if (avs_address[5:0] == `SHIFT_DATA_LOW_IDX) begin
        nxt_shift[3:0] = avs_writedata[3:0];
      end
      if (avs_address[5:0] == `SHIFT_DATA_HIGH_IDX) begin
        nxt_shift[7:4] = avs_writedata[3:0];
      end
    end
    if (avs_read & ~ack_ff & (avs_address[5:0] == `STATUS_IDX)) begin
      nxt_serial_irq_flag = 1'b0;
    end
    case (state_ff)
      ST_START_WAIT: begin
        nxt_bit_counter = 4'h0;
        if (wrStart) begin
          nxt_bit_counter = 4'h0;
          nxt_state       = ST_CLOCK_WAIT;
        end
      end
      ST_CLOCK_WAIT: begin
        if (wrMode1) begin
          nxt_state = ST_START_WAIT;
        end else if (wrStart) begin
          nxt_bit_counter = 4'h0;
        end else if (clkFall) begin
          if (!extClock && !pin_function_select_ff[`CONT_CLOCK_SELECT_BIT]) begin
            nxt_state = ST_CONT_CLOCK;
          end else begin
            // re-entry after noise is the same path
            nxt_state     = ST_TRANSFER;
            nxt_first_low = 1'b1;
            nxt_out       = shift_ff[0];
          end
        end
      end
      // transfer spans first fall to eighth rise
      ST_TRANSFER: begin
        if (wrMode1 || wrStart) begin
          // mode-one write stops clocks and resets counter
          // no flag during first low phase
          nxt_bit_counter = 4'h0;
          nxt_state       = wrMode1 ? ST_START_WAIT : ST_CLOCK_WAIT;
          if (!first_low_ff) begin
            nxt_serial_irq_flag = 1'b1;
          end
        end else if (clkRiseEv) begin
          // count on rise, sample lsb first
          nxt_first_low = 1'b0;
          nxt_shift     = {sin_sync_ff[2], shift_ff[7:1]};
          if (bit_counter_ff == `BITS_PER_TRANSFER - 4'h1) begin
            // external to clock-wait, internal to start-wait
            nxt_bit_counter     = 4'h0;
            nxt_serial_irq_flag = 1'b1;
            nxt_state           = extClock ? ST_CLOCK_WAIT : ST_START_WAIT;
          end else begin
            nxt_bit_counter = bit_counter_ff + 4'h1;
          end
        end else if (clkFall) begin
          nxt_out = shift_ff[0];
        end
      end
      ST_CONT_CLOCK: begin
        if (wrMode1) begin
          nxt_state = ST_START_WAIT;
        end
      end
      default: begin
        nxt_state = ST_START_WAIT;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff           <= ST_START_WAIT;
      bit_counter_ff     <= 4'h0;
      serial_irq_flag_ff <= 1'b0;
      shift_ff           <= 8'h00;
      // low after reset until an idle write or a transfer sets it
      out_ff             <= 1'b0;
      first_low_ff       <= 1'b0;
      idle_level_ff      <= 1'b0;
      pullup_ff          <= 1'b0;
    end else begin
      state_ff           <= nxt_state;
      bit_counter_ff     <= nxt_bit_counter;
      serial_irq_flag_ff <= nxt_serial_irq_flag;
      shift_ff           <= nxt_shift;
      out_ff             <= nxt_out;
      first_low_ff       <= nxt_first_low;
      idle_level_ff      <= nxt_idle_level;
      pullup_ff          <= nxt_pullup;
    end
  end

  // mode register with delayed effect and internal clock generator
  always_comb begin
    nxt_serial_mode_one     = serial_mode_one_ff;
    nxt_pending_mode        = pending_mode_ff;
    nxt_settle              = settle_ff;
    nxt_pin_function_select = pin_function_select_ff;
    nxt_module_clock_gate   = module_clock_gate_ff;
    nxt_sclk_drv            = sclk_drv_ff;
    nxt_pre_cnt             = pre_cnt_ff;
    if (wrMode1) begin
      nxt_pending_mode = avs_writedata[3:0];
      nxt_settle       = `MODE_SETTLE_CYCLES;
    end else if (settle_ff != 2'h0) begin
      nxt_settle = settle_ff - 2'h1;
      // new mode applied after settle delay
      if (settle_ff == 2'h1) begin
        nxt_serial_mode_one = pending_mode_ff;
      end
    end
    // software writes pin function select and module clock gate after this
    if (avs_write & ~ack_ff & avs_byteenable[0]) begin
      if (avs_address[5:0] == `PIN_FUNCTION_SELECT_IDX) begin
        nxt_pin_function_select = avs_writedata[3:0];
      end
      if (avs_address[5:0] == `MODULE_CLOCK_GATE_IDX) begin
        nxt_module_clock_gate = avs_writedata[3:0];
      end
    end
    // internal clock runs only in clock-wait, transfer or continuous state
    if (!extClock && !gated &&
        ((state_ff == ST_TRANSFER) || (state_ff == ST_CONT_CLOCK) ||
         (state_ff == ST_CLOCK_WAIT))) begin
      nxt_pre_cnt = pre_cnt_ff + 2'h1;
      if (pre_cnt_ff == serial_mode_one_ff[3:2]) begin
        nxt_pre_cnt  = 2'h0;
        nxt_sclk_drv = ~sclk_drv_ff;
      end
    end else begin
      nxt_pre_cnt  = 2'h0;
      nxt_sclk_drv = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      serial_mode_one_ff     <= `SERIAL_MODE_ONE_RST;
      pending_mode_ff        <= `SERIAL_MODE_ONE_RST;
      settle_ff              <= 2'h0;
      pin_function_select_ff <= `PIN_FUNCTION_RST;
      module_clock_gate_ff   <= `GATE_RST;
      sclk_drv_ff            <= 1'b1;
      pre_cnt_ff             <= 2'h0;
      sclk_oe_ff             <= 1'b1;
    end else begin
      serial_mode_one_ff     <= nxt_serial_mode_one;
      pending_mode_ff        <= nxt_pending_mode;
      settle_ff              <= nxt_settle;
      pin_function_select_ff <= nxt_pin_function_select;
      module_clock_gate_ff   <= nxt_module_clock_gate;
      sclk_drv_ff            <= nxt_sclk_drv;
      pre_cnt_ff             <= nxt_pre_cnt;
      sclk_oe_ff             <= nxt_sclk_oe;
    end
  end

  // bus answer: one wait cycle, then acknowledge
  always_comb begin
    nxt_ack   = req;
    nxt_rdata = 32'h0000_0000;
    case (avs_address[5:0])
      `SHIFT_DATA_LOW_IDX:  nxt_rdata = {28'h0000000, shift_ff[3:0]};
      `SHIFT_DATA_HIGH_IDX: nxt_rdata = {28'h0000000, shift_ff[7:4]};
      `STATUS_IDX:          nxt_rdata = {25'h0, bit_counter_ff, state_ff,
                                         serial_irq_flag_ff};
      default:              nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff   <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  // outputs straight from flip-flops
  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = ~ack_ff;
  // drive clock only in internal mode
  assign sclkOut         = sclk_drv_ff;
  assign sclkOe          = sclk_oe_ff;
  assign serialOut       = out_ff;
  assign serialOutOe     = pin_function_select_ff[`PIN_DATA_OUT_BIT];
  assign pullupEn        = pullup_ff;
  assign serialIrqFlag   = serial_irq_flag_ff;

endmodule : clocked_serial_interface

// [bench/serial_if_checker.sv]
`timescale 1ns/1ps
`include "serial_if_params.svh"
module serial_if_checker (
  input wire logic        core_clk,        // system clock
  input wire logic        rst,             // sync reset
  input wire logic [7:0]  avs_address,     // word index
  input wire logic        avs_read,        // read strobe
  input wire logic        avs_write,       // write strobe
  input wire logic [31:0] avs_writedata,   // write data
  input wire logic [31:0] avs_readdata,    // read data
  input wire logic        avs_waitrequest, // stall
  input wire logic        sclkIn,          // clock pin level
  input wire logic        sclkOut,         // clock drive
  input wire logic        sclkOe,          // clock enable
  input wire logic        pullupEn,        // pull-up on
  input wire logic        serialIrqFlag    // irq level
);
  logic [3:0] riseCnt_ff, nxt_riseCnt, pulseCnt_ff, nxt_pulseCnt;
  logic       contSel_ff, nxt_contSel, inPrev_ff, outPrev_ff;
  wire        wrDone  = avs_write && !avs_waitrequest;
  wire        mode2Wr = avs_write && avs_address[5:0] == `SERIAL_MODE_TWO_IDX;
  wire        restart = wrDone && (avs_address[5:0] == `START_COMMAND_IDX ||
                                   avs_address[5:0] == `SERIAL_MODE_ONE_IDX);
  // edge counts since the last start or mode-one write; wraps are harmless past the limits
  always_comb begin
    nxt_riseCnt  = riseCnt_ff;
    nxt_pulseCnt = pulseCnt_ff;
    nxt_contSel  = contSel_ff;
    if (sclkIn && !inPrev_ff && !sclkOe) nxt_riseCnt = riseCnt_ff + 4'h1;
    if (!sclkOut && outPrev_ff && sclkOe) nxt_pulseCnt = pulseCnt_ff + 4'h1;
    if (wrDone && avs_address[5:0] == `PIN_FUNCTION_SELECT_IDX) nxt_contSel = !avs_writedata[3];
    if (restart) begin
      nxt_riseCnt  = 4'h0;
      nxt_pulseCnt = 4'h0;
    end
  end
  // register helper state
  always_ff @(posedge core_clk) begin
    riseCnt_ff  <= rst ? 4'h0 : nxt_riseCnt;
    pulseCnt_ff <= rst ? 4'h0 : nxt_pulseCnt;
    contSel_ff  <= rst ? 1'b0 : nxt_contSel;
    inPrev_ff   <= sclkIn;
    outPrev_ff  <= sclkOut;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence write_done(idx);
    wrDone && avs_address[5:0] == idx;
  endsequence
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
    else $error("bus request not answered");
  ack_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address[5:0] == 6'h3F
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  reset_clear_a: assert property ($fell(rst) |-> !pullupEn && !serialIrqFlag)
    else $error("reset values wrong");
  irq_hold_a: assert property (
    serialIrqFlag && !(avs_read && avs_address[5:0] == `STATUS_IDX) |=> serialIrqFlag)
    else $error("irq flag dropped");
  pullup_write_a: assert property ($changed(pullupEn) |-> $past(mode2Wr))
    else $error("pull-up changed without write");
  ext_clock_a: assert property (write_done(`SERIAL_MODE_ONE_IDX) ##0
    avs_writedata[2:0] == `MODE_EXT_CLOCK_CODE |-> ##[1:4] !sclkOe) else $error("clock still driven");
  int_clock_a: assert property (write_done(`SERIAL_MODE_ONE_IDX) ##0
    avs_writedata[2:0] != `MODE_EXT_CLOCK_CODE |-> ##[1:4] sclkOe) else $error("clock not driven");
  pulse_limit_a: assert property (!contSel_ff |-> pulseCnt_ff <= 4'h8)
    else $error("more than eight clocks out");
  eighth_edge_a: assert property (
    sclkIn && !inPrev_ff && !sclkOe && riseCnt_ff == 4'h7 |-> ##[1:8] serialIrqFlag)
    else $error("no irq after eighth clock");
endmodule : serial_if_checker
bind clocked_serial_interface serial_if_checker u_serial_if_checker (
  .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .sclkIn(sclkIn), .sclkOut(sclkOut), .sclkOe(sclkOe),
  .pullupEn(pullupEn), .serialIrqFlag(serialIrqFlag));

// [bench/serial_peer_model.sv]
`timescale 1ns/1ps
module serial_peer_model #(
  parameter int HALF = 8          // system clocks per half period
) (
  input  wire logic core_clk,     // system clock
  input  wire logic serialOut,    // device data out
  output logic      peerClk,      // clock the peer drives
  output logic      peerData      // data the peer drives
);
  logic [7:0] rxByte;             // bits seen from the device
  // clock stands high outside frames
  initial begin
    peerClk  = 1'b1;
    peerData = 1'b0;
    rxByte   = 8'h00;
  end
  // lsb first, shifted on fall and taken on rise
  task automatic run(input logic [7:0] txByte, input int pulses);
    for (int i = 0; i < pulses; i++) begin
      repeat (HALF) @(posedge core_clk);
      peerClk  <= 1'b0;
      peerData <= txByte[i % 8];
      repeat (HALF) @(posedge core_clk);
      peerClk <= 1'b1;
      rxByte  <= {serialOut, rxByte[7:1]};
    end
    repeat (HALF) @(posedge core_clk);
    // released line shows the inverse so a stale bit cannot pass by luck
    peerData <= ~peerData;
  endtask : run
  // a bare clock level, for pauses inside a frame
  task automatic set_clk(input logic lvl);
    @(posedge core_clk);
    peerClk <= lvl;
  endtask : set_clk
endmodule : serial_peer_model

// [bench/test_clocked_serial_interface.sv]
`timescale 1ns/1ps
`include "serial_if_params.svh"
`define CHECK_EQ(what, exp, act) \
  begin \
    num_checks++; \
    if ((act) !== (exp)) begin \
      errors++; \
      $display("MISMATCH %s expected %0h seen %0h", what, exp, act); \
    end \
  end
module test_clocked_serial_interface import serial_if_pkg::*;;
  localparam logic [7:0] MODE1 = {2'b00, `SERIAL_MODE_ONE_IDX};
  localparam logic [7:0] MODE2 = {2'b00, `SERIAL_MODE_TWO_IDX};
  localparam logic [7:0] PINF  = {2'b00, `PIN_FUNCTION_SELECT_IDX};
  localparam logic [7:0] SHLO  = {2'b00, `SHIFT_DATA_LOW_IDX};
  localparam logic [7:0] SHHI  = {2'b00, `SHIFT_DATA_HIGH_IDX};
  localparam logic [7:0] START = {2'b00, `START_COMMAND_IDX};
  logic        core_clk, rst, avs_read, avs_write, sclkIn, serialIn, peerClk;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdata;
  logic        avs_waitrequest, sclkOut, sclkOe, serialOut, serialOutOe, pullupEn;
  logic        serialIrqFlag, sclkPrev;
  int          errors, num_checks, falls;
  // the pin follows whoever drives it
  assign sclkIn = sclkOe ? sclkOut : peerClk;
  clocked_serial_interface u_clocked_serial_interface (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sclkIn(sclkIn),
    .sclkOut(sclkOut), .sclkOe(sclkOe), .serialIn(serialIn), .serialOut(serialOut),
    .serialOutOe(serialOutOe), .pullupEn(pullupEn), .serialIrqFlag(serialIrqFlag));
  serial_peer_model #(.HALF(8)) u_serial_peer_model (
    .core_clk(core_clk), .serialOut(serialOut), .peerClk(peerClk), .peerData(serialIn));
  // 10 MHz system clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // count falls of the driven clock
  always @(posedge core_clk) begin
    sclkPrev <= sclkOut;
    if (sclkPrev && !sclkOut && sclkOe) falls <= falls + 1;
  end
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [3:0] data);
    int n;
    @(posedge core_clk);
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_address   <= idx;
    avs_writedata <= {28'h0, data};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      errors++;
      $display("MISMATCH waitrequest expected 0 seen 1");
    end
    rdata = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // waits for the clock pin high first, then lets a new mode settle
  // clock pin high first, settle before start
  task automatic sw_cmd(input logic [7:0] idx, input logic [3:0] data);
    for (int n = 0; n < 100 && sclkIn !== 1'b1; n++) @(posedge core_clk);
    bus(1'b1, idx, data);
    repeat (2) @(posedge core_clk);
  endtask : sw_cmd
  // reading status also clears the flag
  task automatic expect_status(input serial_state_type st, input logic [3:0] cnt,
                               input logic irq, input bit useCnt);
    bus(1'b0, {2'b00, `STATUS_IDX}, 4'h0);
    `CHECK_EQ("state", st, rdata[2:1])
    if (useCnt) `CHECK_EQ("counter", cnt, rdata[6:3])
    `CHECK_EQ("irq", irq, rdata[0])
  endtask : expect_status
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  // the sequence needs a few thousand cycles at most
  initial begin
    #(2_000_000);
    errors++;
    complete_run();
  end
  // main sequence
  initial begin
    {rst, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 42'h0};
    {errors, num_checks, falls} = '0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    `CHECK_EQ("pullup", 1'b0, pullupEn)
    expect_status(ST_START_WAIT, 4'h0, 1'b0, 1'b1);
    bus(1'b1, 8'h3F, 4'hF);
    bus(1'b0, 8'h3F, 4'h0);
    `CHECK_EQ("unmapped", 32'h0, rdata)
    bus(1'b1, MODE2, 4'h2);
    `CHECK_EQ("idle high", 1'b1, serialOut)
    bus(1'b1, MODE2, 4'h4);
    `CHECK_EQ("idle low", 1'b0, serialOut)
    `CHECK_EQ("pullup on", 1'b1, pullupEn)
    // external clock, one whole byte each way
    sw_cmd(MODE1, 4'h7);
    // pin function set while idle, after mode one is written
    bus(1'b1, PINF, 4'hE);
    `CHECK_EQ("clock input", 1'b0, sclkOe)
    bus(1'b1, SHLO, 4'h5);
    bus(1'b1, SHHI, 4'hA);
    sw_cmd(START, 4'h0);
    expect_status(ST_CLOCK_WAIT, 4'h0, 1'b0, 1'b1);
    u_serial_peer_model.run(8'h3C, 8);
    expect_status(ST_CLOCK_WAIT, 4'h0, 1'b1, 1'b1);
    `CHECK_EQ("sent byte", 8'hA5, u_serial_peer_model.rxByte)
    // shift data read only once the transfer is over
    bus(1'b0, SHLO, 4'h0);
    `CHECK_EQ("rx low", 4'hC, rdata[3:0])
    bus(1'b0, SHHI, 4'h0);
    `CHECK_EQ("rx high", 4'h3, rdata[3:0])
    // restart and mode-one abort in mid-transfer
    sw_cmd(START, 4'h0);
    u_serial_peer_model.run(8'h00, 3);
    bus(1'b1, MODE2, 4'h0);
    `CHECK_EQ("pullup held", 1'b1, pullupEn)
    expect_status(ST_TRANSFER, 4'h3, 1'b0, 1'b1);
    sw_cmd(START, 4'h0);
    expect_status(ST_CLOCK_WAIT, 4'h0, 1'b1, 1'b1);
    u_serial_peer_model.run(8'h00, 4);
    expect_status(ST_TRANSFER, 4'h4, 1'b0, 1'b1);
    sw_cmd(MODE1, 4'h7);
    expect_status(ST_START_WAIT, 4'h0, 1'b1, 1'b1);
    // two noise pulses, then the dummy write reports the error
    sw_cmd(START, 4'h0);
    u_serial_peer_model.run(8'h00, 10);
    expect_status(ST_TRANSFER, 4'h2, 1'b1, 1'b1);
    sw_cmd(MODE1, 4'h7);
    expect_status(ST_START_WAIT, 4'h0, 1'b1, 1'b1);
    // start while the first low phase lasts leaves the flag clear
    sw_cmd(START, 4'h0);
    u_serial_peer_model.set_clk(1'b0);
    repeat (8) @(posedge core_clk);
    bus(1'b1, START, 4'h0);
    expect_status(ST_CLOCK_WAIT, 4'h0, 1'b0, 1'b1);
    u_serial_peer_model.set_clk(1'b1);
    sw_cmd(MODE1, 4'h0);
    expect_status(ST_START_WAIT, 4'h0, 1'b0, 1'b1);
    // internal clock stops after eight pulses
    `CHECK_EQ("clock output", 1'b1, sclkOe)
    falls <= 0;
    sw_cmd(START, 4'h0);
    for (int i = 0; i < 300 && serialIrqFlag !== 1'b1; i++) @(posedge core_clk);
    repeat (20) @(posedge core_clk);
    `CHECK_EQ("pulses", 8, falls)
    `CHECK_EQ("clock idle", 1'b1, sclkOut)
    expect_status(ST_START_WAIT, 4'h0, 1'b1, 1'b1);
    // continuous clock, then left by a mode-one write
    bus(1'b1, PINF, 4'h2);
    sw_cmd(START, 4'h0);
    repeat (20) @(posedge core_clk);
    expect_status(ST_CONT_CLOCK, 4'h0, 1'b0, 1'b0);
    sw_cmd(MODE1, 4'h0);
    expect_status(ST_START_WAIT, 4'h0, 1'b0, 1'b1);
    complete_run();
  end
endmodule : test_clocked_serial_interface
